// *** hw/crc_byte_engine.sv ***
// byte-serial 16-bit checksum engine with eight preset algorithms
`timescale 1ns/100ps
module crc_byte_engine #(
    parameter int ADDR_W = crc_pkg::ADDR_W,
    parameter int DATA_W = crc_pkg::DATA_W
) (
    input  wire logic              ref_clk_i,
    input  wire logic              rstn_i,
    input  wire logic              clock_gate_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    output logic                   byte_ready_o,
    output logic [crc_pkg::CRC_W-1:0] result_o
);
    import crc_pkg::*;

    // ------------------------------------------------------------------
    // algorithm lookup
    // ------------------------------------------------------------------

    // polynomial for an algorithm code
    function automatic logic [CRC_W-1:0] algo_poly(input logic [ALGO_W-1:0] algo);
        algo_poly = ALGO_POLY_B[algo] ? POLY_B : POLY_A;
    endfunction

    // starting remainder for an algorithm code
    function automatic logic [CRC_W-1:0] algo_init(input logic [ALGO_W-1:0] algo);
        algo_init = ALGO_INIT_1[algo] ? CRC_ONES : CRC_ZEROS;
    endfunction

    // final xor constant for an algorithm code
    function automatic logic [CRC_W-1:0] algo_xor(input logic [ALGO_W-1:0] algo);
        algo_xor = ALGO_XOR_1[algo] ? CRC_ONES : CRC_ZEROS;
    endfunction

    // bit reversal of a byte
    function automatic logic [BYTE_W-1:0] rev_byte(input logic [BYTE_W-1:0] b);
        for (int i = 0; i < BYTE_W; i++) begin
            rev_byte[i] = b[BYTE_W-1-i];
        end
    endfunction

    // bit reversal of a remainder
    function automatic logic [CRC_W-1:0] rev_crc(input logic [CRC_W-1:0] c);
        for (int i = 0; i < CRC_W; i++) begin
            rev_crc[i] = c[CRC_W-1-i];
        end
    endfunction

    // one byte of modulo-2 division, msb first on the (maybe reversed) byte
    function automatic logic [CRC_W-1:0] fold_byte(input logic [CRC_W-1:0]  crc,
                                                   input logic [BYTE_W-1:0] b,
                                                   input logic [ALGO_W-1:0] algo);
        logic [BYTE_W-1:0] din;
        logic [CRC_W-1:0]  acc;
        logic              fb;
        din = ALGO_REFLECT[algo] ? rev_byte(b) : b;
        acc = crc;
        fb  = 1'b0;
        for (int i = BYTE_W - 1; i >= 0; i--) begin
            fb  = acc[CRC_W-1] ^ din[i];
            acc = {acc[CRC_W-2:0], 1'b0} ^ (fb ? algo_poly(algo) : CRC_ZEROS);
        end
        fold_byte = acc;
    endfunction

    // check value presented to software
    function automatic logic [CRC_W-1:0] finish(input logic [CRC_W-1:0]  crc,
                                                input logic [ALGO_W-1:0] algo);
        logic [CRC_W-1:0] r;
        r      = ALGO_REFLECT[algo] ? rev_crc(crc) : crc;
        finish = r ^ algo_xor(algo);
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [MODE_W-1:0] mode_q;
    logic [MODE_W-1:0] mode_d;
    logic [CRC_W-1:0]  crc_q;
    logic [CRC_W-1:0]  crc_d;
    logic [BYTE_W-1:0] last_byte_q;
    logic [DATA_W-1:0] rdata_q;
    logic [CRC_W-1:0]  result_q;
    crc_state_t        state_q;
    crc_state_t        state_d;

    logic              ctrl_wr;
    logic              input_wr;
    logic              mode_ok;
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic              buf_out_ready;
    logic [BYTE_W-1:0] buf_out_data;
    logic              absorb;
    logic [CRC_W-1:0]  result_d;
    logic [ALGO_W-1:0] algo_q;
    logic [ALGO_W-1:0] algo_d;

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------

    // writes only count while software has the clock gate open
    always_comb begin
        ctrl_wr  = 1'b0;
        input_wr = 1'b0;
        if (wr_i && clock_gate_i) begin
            if (addr_i == CTRL_OFS) begin
                ctrl_wr = 1'b1;
            end else if (addr_i == INPUT_OFS) begin
                input_wr = 1'b1;
            end
        end
    end

    // codes above the last algorithm are not stored, so mode always names a table row
    assign mode_ok = (wdata_i[MODE_W-1:0] <= MODE_LAST);
    assign algo_q  = mode_q[ALGO_W-1:0];
    assign algo_d  = mode_d[ALGO_W-1:0];

    // ------------------------------------------------------------------
    // input buffer
    // ------------------------------------------------------------------

    // a full buffer refuses the write; byte_ready_o tells software to hold off
    assign byte_ready_o = buf_in_ready;

    // the engine stalls for one cycle while a mode write reloads the remainder,
    // so a queued byte is folded under the new mode rather than lost
    assign buf_out_ready = !(ctrl_wr && mode_ok);
    assign absorb        = buf_out_valid && buf_out_ready;

    crc_pair_buf #(
        .WIDTH (BYTE_W),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .ref_clk_i   (ref_clk_i),
        .rstn_i      (rstn_i),
        .in_valid_i  (input_wr),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (wdata_i[BYTE_W-1:0]),
        .out_valid_o (buf_out_valid),
        .out_ready_i (buf_out_ready),
        .out_data_o  (buf_out_data)
    );

    // ------------------------------------------------------------------
    // mode register
    // ------------------------------------------------------------------

    // next mode: a legal code replaces the old one
    always_comb begin
        mode_d = mode_q;
        if (ctrl_wr && mode_ok) begin
            mode_d = wdata_i[MODE_W-1:0];
        end
    end

    // algorithm selection, algorithm 4 after reset
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode_q <= MODE_RESET;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ------------------------------------------------------------------
    // remainder
    // ------------------------------------------------------------------

    // reload beats absorption; bytes leave the buffer in arrival order
    always_comb begin
        crc_d = crc_q;
        if (ctrl_wr && mode_ok) begin
            crc_d = algo_init(algo_d);
        end else if (absorb) begin
            crc_d = fold_byte(crc_q, buf_out_data, algo_q);
        end
    end

    // running remainder, reset to the default algorithm's start value
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            crc_q <= algo_init(MODE_RESET[ALGO_W-1:0]);
        end else begin
            crc_q <= crc_d;
        end
    end

    // last byte written, readable back at the input offset
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_byte_q <= BYTE_RESET;
        end else if (input_wr && buf_in_ready) begin
            last_byte_q <= wdata_i[BYTE_W-1:0];
        end
    end

    // ------------------------------------------------------------------
    // life cycle
    // ------------------------------------------------------------------

    // the result reads its reset pattern until the first mode write or byte
    always_comb begin
        state_d = state_q;
        case (state_q)
            CRC_FRESH: begin
                if ((ctrl_wr && mode_ok) || absorb) begin
                    state_d = CRC_ACTIVE;
                end
            end
            CRC_ACTIVE: begin
                state_d = CRC_ACTIVE;
            end
            default: begin
                state_d = CRC_FRESH;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= CRC_FRESH;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // result
    // ------------------------------------------------------------------

    // computed from next-state values so a read right after a byte sees it
    always_comb begin
        if (state_d == CRC_FRESH) begin
            result_d = RESULT_RESET;
        end else begin
            result_d = finish(crc_d, algo_d);
        end
    end

    // registered copy of the check value for the output port
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            result_q <= RESULT_RESET;
        end else begin
            result_q <= result_d;
        end
    end

    assign result_o = result_q;

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------

    // read data stand for exactly one cycle after the strobe, zero otherwise;
    // reads have no side effect on the engine
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= READ_ZERO;
        end else begin
            rdata_q <= READ_ZERO;
            if (rd_i) begin
                if (addr_i == CTRL_OFS) begin
                    rdata_q <= {{(DATA_W - MODE_W){1'b0}}, mode_q};
                end else if (addr_i == INPUT_OFS) begin
                    rdata_q <= {{(DATA_W - BYTE_W){1'b0}}, last_byte_q};
                end else if (addr_i == RESULT_OFS) begin
                    rdata_q <= {{(DATA_W - CRC_W){1'b0}}, result_d};
                end
            end
        end
    end

    assign rdata_o = rdata_q;

endmodule

// *** hw/crc_pair_buf.sv ***
// small valid/ready buffer holding input bytes on their way to the engine
`timescale 1ns/100ps
module crc_pair_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic             push;
    logic             pop;

    // honest flags straight from the occupancy count
    assign in_ready_o  = (count_q != CNT_W'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem_q[rd_ptr_q];

    // storage: entries only change on a push
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    // pointers wrap at depth, which need not be a power of two
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
            end
        end
    end

    // occupancy
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            count_q <= '0;
        end else if (push && !pop) begin
            count_q <= count_q + 1'b1;
        end else if (pop && !push) begin
            count_q <= count_q - 1'b1;
        end
    end
endmodule

// *** include/crc_pkg.sv ***
// shared constants for the 16-bit byte-wide checksum engine
package crc_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int DATA_W    = 32;
    localparam int ADDR_W    = 8;
    localparam int BYTE_W    = 8;
    localparam int CRC_W     = 16;
    localparam int MODE_W    = 4;
    localparam int ALGO_W    = 3;
    localparam int BUF_DEPTH = 2;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] INPUT_OFS  = 8'h08;
    localparam logic [ADDR_W-1:0] RESULT_OFS = 8'h0C;

    // ------------------------------------------------------------------
    // reset values and mode codes
    // ------------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_RESET   = 4'h4;
    localparam logic [MODE_W-1:0] MODE_LAST    = 4'h7;
    localparam logic [CRC_W-1:0]  RESULT_RESET = 16'hFFFF;
    localparam logic [BYTE_W-1:0] BYTE_RESET   = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO    = 32'h0000_0000;

    // ------------------------------------------------------------------
    // generator polynomials, top bit implicit
    // ------------------------------------------------------------------
    localparam logic [CRC_W-1:0] POLY_A    = 16'h8005;
    localparam logic [CRC_W-1:0] POLY_B    = 16'h1021;
    localparam logic [CRC_W-1:0] CRC_ZEROS = 16'h0000;
    localparam logic [CRC_W-1:0] CRC_ONES  = 16'hFFFF;

    // ------------------------------------------------------------------
    // per-algorithm property masks, bit n belongs to algorithm n
    // ------------------------------------------------------------------
    localparam logic [7:0] ALGO_POLY_B  = 8'hF0; // 4..7 use POLY_B
    localparam logic [7:0] ALGO_REFLECT = 8'h5F; // in and out reflection together
    localparam logic [7:0] ALGO_INIT_1  = 8'h6C; // start from all ones
    localparam logic [7:0] ALGO_XOR_1   = 8'h46; // final xor with all ones

    // engine life cycle: fresh after reset until first mode write or byte
    typedef enum logic {
        CRC_FRESH,
        CRC_ACTIVE
    } crc_state_t;

endpackage

// *** test/crc_byte_engine_properties.sv ***
// concurrent checks on the register port of the checksum engine
`timescale 1ns/100ps
module crc_byte_engine_checker
    import crc_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rstn_i,
    input  wire logic                      clock_gate_i,
    input  wire logic [ADDR_W-1:0]         addr_i,
    input  wire logic [DATA_W-1:0]         wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    input  wire logic [DATA_W-1:0]         rdata_o,
    input  wire logic                      byte_ready_o,
    input  wire logic [crc_pkg::CRC_W-1:0] result_o
);
    import crc_pkg::*;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    logic ctl_wr;
    logic in_wr;

    // accepted writes only; a gated-off unit must not see them
    assign ctl_wr = wr_i && clock_gate_i && addr_i == CTRL_OFS;
    assign in_wr  = wr_i && clock_gate_i && byte_ready_o && addr_i == INPUT_OFS;

    // value shown right after a reload: init xor final constant
    function automatic logic [15:0] fresh_val(input logic [31:0] w);
        return (w[3:0] == 4'h1 || w[3:0] == 4'h3 || w[3:0] == 4'h5) ? 16'hFFFF : 16'h0000;
    endfunction

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    a_rdata_idle: assert property (!rd_i |=> rdata_o == '0)
        else $error("read data not zero outside a read answer");
    a_result_read: assert property (rd_i && addr_i == RESULT_OFS
        |=> rdata_o == {16'h0000, result_o})
        else $error("result read does not match the running value");
    a_mode_reload: assert property (ctl_wr && wdata_i[3:0] <= MODE_LAST
        |=> result_o == fresh_val($past(wdata_i)))
        else $error("mode write did not load the initial value");
    a_reads_harmless: assert property (!$past(wr_i) && !$past(wr_i, 2)
        |-> $stable(result_o))
        else $error("result moved without a write");
    a_input_readback: assert property (in_wr ##1 (rd_i && addr_i == INPUT_OFS)
        |=> rdata_o == ($past(wdata_i, 2) & 32'h0000_00FF))
        else $error("input register readback wrong");
    a_mode_readback: assert property ((ctl_wr && wdata_i[3:0] <= MODE_LAST) ##1
        (rd_i && addr_i == CTRL_OFS) |=> rdata_o == ($past(wdata_i, 2) & 32'h0000_000F))
        else $error("control readback wrong");
    a_bad_mode_kept: assert property (!wr_i ##1 (ctl_wr && wdata_i[3:0] > MODE_LAST)
        |=> $stable(result_o))
        else $error("illegal mode code changed the result");
    a_gate_drop: assert property (!wr_i ##1 (wr_i && !clock_gate_i)
        |=> $stable(result_o))
        else $error("write taken while the unit clock was off");
    a_unmapped_zero: assert property (rd_i && addr_i != CTRL_OFS
        && addr_i != INPUT_OFS && addr_i != RESULT_OFS |=> rdata_o == '0)
        else $error("unmapped read returned data");

    // main scenarios reached
    c_mode_write: cover property (ctl_wr);
    c_byte_write: cover property (in_wr ##1 rd_i);
    c_result_read: cover property (rd_i && addr_i == RESULT_OFS);
endmodule

bind crc_byte_engine crc_byte_engine_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_checker (
    .ref_clk_i    (ref_clk_i),
    .rstn_i       (rstn_i),
    .clock_gate_i (clock_gate_i),
    .addr_i       (addr_i),
    .wdata_i      (wdata_i),
    .wr_i         (wr_i),
    .rd_i         (rd_i),
    .rdata_o      (rdata_o),
    .byte_ready_o (byte_ready_o),
    .result_o     (result_o)
);

// *** test/crc_byte_engine_tb.sv ***
// self-checking bench for the byte-serial checksum engine
`timescale 1ns/100ps
module crc_byte_engine_tb;
    import crc_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic              ref_clk_i;
    logic              rstn_i;
    logic              clock_gate_i;
    logic              wr_i;
    logic              rd_i;
    logic              byte_ready_o;
    logic [ADDR_W-1:0] addr_i;
    logic [DATA_W-1:0] wdata_i;
    logic [DATA_W-1:0] rdata_o;
    logic [CRC_W-1:0]  result_o;
    logic [DATA_W-1:0] v;
    logic [7:0]        msg [$];
    logic [7:0]        none [$];
    int                miscompares;
    int                n_checks;
    int                cycles;

    // design under test
    crc_byte_engine #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) uut (
        .ref_clk_i    (ref_clk_i),
        .rstn_i       (rstn_i),
        .clock_gate_i (clock_gate_i),
        .addr_i       (addr_i),
        .wdata_i      (wdata_i),
        .wr_i         (wr_i),
        .rd_i         (rd_i),
        .rdata_o      (rdata_o),
        .byte_ready_o (byte_ready_o),
        .result_o     (result_o)
    );

    // 10 MHz clock
    always #50 ref_clk_i = ~ref_clk_i;

    // hang guard: the run needs well under a thousand cycles
    always @(posedge ref_clk_i) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            miscompares = miscompares + 1;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // bitwise reference; reflected modes flip each byte in, the remainder out
    function automatic logic [15:0] crc_ref(input int m, input logic [7:0] q [$]);
        logic [15:0] c;
        logic [15:0] poly;
        logic [7:0]  b;
        logic        refl;
        poly = (m < 4) ? 16'h8005 : 16'h1021;
        refl = (m != 5) && (m != 7);
        c = (m == 2 || m == 3 || m == 5 || m == 6) ? 16'hFFFF : 16'h0000;
        foreach (q[i]) begin
            b = refl ? {<<{q[i]}} : q[i];
            c = c ^ {b, 8'h00};
            repeat (8)
                c = c[15] ? ((c << 1) ^ poly) : (c << 1);
        end
        if (refl)
            c = {<<{c}};
        return c ^ ((m == 1 || m == 2 || m == 6) ? 16'hFFFF : 16'h0000);
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            miscompares = miscompares + 1;
        end
    endtask

    // every bus signal is assigned once, right after an edge
    task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        wr_i    <= w;
        rd_i    <= r;
        addr_i  <= a;
        wdata_i <= d;
    endtask

    task automatic rd_reg(input logic [7:0] a);
        bus(1'b0, 1'b1, a, 32'h0);
        bus(1'b0, 1'b0, a, 32'h0);
        #1;
        v = rdata_o;
    endtask

    // upper write bits carry junk that the unit has to drop
    task automatic set_mode(input logic [3:0] m);
        bus(1'b1, 1'b0, CTRL_OFS, {28'hABCDEF0, m});
        bus(1'b0, 1'b0, CTRL_OFS, 32'h0);
        #1;
    endtask

    task automatic feed(input logic [7:0] q [$]);
        foreach (q[i])
            bus(1'b1, 1'b0, INPUT_OFS, {24'hA5A5A5, q[i]});
        bus(1'b0, 1'b0, INPUT_OFS, 32'h0);
        bus(1'b0, 1'b0, INPUT_OFS, 32'h0);
        #1;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        #1;
        chk("result_o", 32'h0000_FFFF, 32'(result_o));
        chk("byte_ready_o", 32'h1, 32'(byte_ready_o));
        chk("rdata_o", 32'h0, rdata_o);
        rd_reg(CTRL_OFS);
        chk("control", 32'h0000_0004, v);
        rd_reg(RESULT_OFS);
        chk("result", 32'h0000_FFFF, v);
        rd_reg(INPUT_OFS);
        chk("input", 32'h0, v);
        $display("test reset done");
    endtask

    task automatic test_algos();
        msg = '{8'h00, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77};
        for (int m = 0; m < 8; m++) begin
            set_mode(4'(m));
            chk("fresh", 32'(crc_ref(m, none)), 32'(result_o));
            feed(msg);
            chk("result_o", 32'(crc_ref(m, msg)), 32'(result_o));
            rd_reg(RESULT_OFS);
            chk("result", 32'(crc_ref(m, msg)), v);
            rd_reg(CTRL_OFS);
            chk("control", 32'(m), v);
        end
        $display("test algorithms done");
    endtask

    // three bytes sent under mode 7, each read right behind its write
    task automatic test_stream();
        bus(1'b1, 1'b0, CTRL_OFS, 32'h0000_0007);
        rd_reg(CTRL_OFS);
        chk("control", 32'h0000_0007, v);
        bus(1'b1, 1'b0, INPUT_OFS, 32'hFFFF_FF12);
        rd_reg(RESULT_OFS);
        msg = '{8'h12};
        chk("result", 32'(crc_ref(7, msg)), v);
        bus(1'b1, 1'b0, INPUT_OFS, 32'hFFFF_FF34);
        rd_reg(RESULT_OFS);
        msg.push_back(8'h34);
        chk("result", 32'(crc_ref(7, msg)), v);
        rd_reg(INPUT_OFS);
        chk("input", 32'h0000_0034, v);
        bus(1'b1, 1'b0, INPUT_OFS, 32'hFFFF_FF56);
        rd_reg(INPUT_OFS);
        chk("input", 32'h0000_0056, v);
        $display("test stream done");
    endtask

    task automatic test_refuse();
        set_mode(4'h4);
        msg = '{8'h5A};
        feed(msg);
        @(posedge ref_clk_i);
        clock_gate_i <= 1'b0;
        bus(1'b1, 1'b0, CTRL_OFS, 32'h0);
        bus(1'b1, 1'b0, INPUT_OFS, 32'h0000_00FF);
        bus(1'b0, 1'b0, INPUT_OFS, 32'h0);
        clock_gate_i <= 1'b1;
        for (int c = 8; c < 16; c++)
            bus(1'b1, 1'b0, CTRL_OFS, 32'(c));
        bus(1'b1, 1'b0, 8'h04, 32'h0000_0001);
        rd_reg(CTRL_OFS);
        chk("control", 32'h0000_0004, v);
        rd_reg(RESULT_OFS);
        chk("result", 32'(crc_ref(4, msg)), v);
        rd_reg(8'h04);
        chk("unmapped", 32'h0, v);
        rd_reg(RESULT_OFS);
        chk("result", 32'(crc_ref(4, msg)), v);
        $display("test refusals done");
    endtask

    task automatic test_midreset();
        feed(msg);
        @(posedge ref_clk_i);
        rstn_i <= 1'b0;
        #1;
        chk("result_o", 32'h0000_FFFF, 32'(result_o));
        repeat (3) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        test_reset();
        $display("test mid-run reset done");
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // main sequence; the unit clock is on before any access
    initial begin
        ref_clk_i    = 1'b0;
        rstn_i       = 1'b0;
        clock_gate_i = 1'b1;
        wr_i         = 1'b0;
        rd_i         = 1'b0;
        addr_i       = '0;
        wdata_i      = '0;
        miscompares  = 0;
        n_checks     = 0;
        cycles       = 0;
        repeat (3) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        test_reset();
        test_algos();
        test_stream();
        test_refuse();
        test_midreset();
        complete_run();
    end
endmodule
